// ---- design/rcs_supervisor.v ----
// remote control supervisor: link watchdog, analog takeover, alarm latch
// assumes all inputs synchronous to clk_sys; set values already sampled
// How it works
// - watchdog supervises only the controlling digital link, idle otherwise
// - every received message restarts the timeout; expiry only without messages
// - on expiry the digital link loses remote control
// - on expiry with output on, output follows handoff setting
// - watchdog enable commands accepted any time while the digital link holds control
// - new timeout value loads only after the running interval elapses
// - watchdog independent of network connection timeout; both may expire
// - voltage, current, power set values all from analog port together
// - resistance set value from analog port only with resistance pin
// - displayed set values are analog ones during analog takeover, resistance only with resistance pin
// - selectable 5 V or 10 V range, full scale is 100 percent
// - set and actual values share 26214 step resolution
// - analog set values clipped to configured adjustment limits
// - takeover needs takeover pin; standby pin works without takeover
// - protection and alarm thresholds never come from the analog port
// - alarm during analog takeover switches output off as manual
// - alarms reported on analog alarm outputs are selectable
// - overvoltage, overcurrent, overpower alarms latched until acknowledged
// - standby pin high-low-high with low of 50 ms clears latches
// - digital takeover rejected with error while analog takeover active
// - takeover pin ignored while a digital link holds control
// - takeover pin low selects analog, high or open selects manual
`timescale 1ns/1ps
`include "rcs_defs.vh"
module rcs_supervisor (
  input wire clk_sys, // system clock
  input wire reset_n, // synchronous reset
  input wire start_done, // start phase finished
  input wire remote_allowed, // remote control not locked
  input wire dig_take_req, // digital takeover request pulse
  input wire dig_release_req, // digital release request pulse
  input wire msg_valid, // complete valid message pulse
  input wire wdog_en_wr, // watchdog enable write pulse
  input wire wdog_en_val, // watchdog enable value
  input wire tmo_wr, // timeout write pulse
  input wire [15:0] tmo_val, // timeout in ticks
  input wire handoff_keep_on, // keep output on after handoff
  input wire range_10v, // analog range 10 V when high
  input wire takeover_pin, // analog takeover pin, low active
  input wire resistance_mode_pin, // resistance mode request
  input wire output_standby_pin, // standby pin, low switches off
  input wire output_on_req, // output on request from panel/digital
  input wire [15:0] voltage_setpoint_input, // analog voltage sample
  input wire [15:0] current_setpoint_input, // analog current sample
  input wire [15:0] power_setpoint_input, // analog power sample
  input wire [15:0] resistance_setpoint_input, // analog resistance sample
  input wire [15:0] panel_v, // panel voltage set value
  input wire [15:0] panel_i, // panel current set value
  input wire [15:0] panel_p, // panel power set value
  input wire [15:0] panel_r, // panel resistance set value
  input wire [15:0] lim_v, // voltage adjustment limit
  input wire [15:0] lim_i, // current adjustment limit
  input wire [15:0] lim_p, // power adjustment limit
  input wire [15:0] lim_r, // resistance adjustment limit
  input wire [15:0] act_v, // actual voltage, full scale 26214
  input wire [15:0] act_i, // actual current, full scale 26214
  input wire [4:0] alarm_raw, // raw alarm events
  input wire [4:0] alarm_sel, // alarms routed to analog outputs
  output reg digital_remote, // digital link holds control
  output reg analog_remote, // analog takeover active
  output reg dig_take_err, // digital takeover rejected pulse
  output reg wdog_expired, // watchdog expiry pulse
  output reg output_enable, // power output enable
  output reg [15:0] set_v, // applied and displayed voltage set
  output reg [15:0] set_i, // applied and displayed current set
  output reg [15:0] set_p, // applied and displayed power set
  output reg [15:0] set_r, // applied and displayed resistance set
  output reg r_from_analog, // resistance set from analog port
  output reg [15:0] voltage_actual_output, // actual voltage to port
  output reg [15:0] current_actual_output, // actual current to port
  output reg ref_10v, // reference output 10 V when high
  output reg [4:0] alarm_latched, // alarm state
  output reg analog_alarm_thermal, // alarm output 1
  output reg analog_alarm_protect // alarm output 2
);

  localparam ACK_W = 22;
  localparam TICK_W = 16;
  localparam [31:0] ACK_LOW_FULL = `RCS_ACK_LOW_CYC;
  localparam [31:0] TICK_FULL = `RCS_TICK_CYC;
  localparam [ACK_W-1:0] ACK_LOW_CYC = ACK_LOW_FULL[ACK_W-1:0];
  localparam [TICK_W-1:0] TICK_CYC = TICK_FULL[TICK_W-1:0];
  localparam [15:0] FULL_SCALE = `RCS_FULL_SCALE;
  localparam [4:0] PROT_MASK = 5'h1C;

  // clip to limit and to full scale
  function [15:0] clip;
    input [15:0] v;
    input [15:0] lim;
    reg [15:0] m;
    begin
      m = (lim < FULL_SCALE) ? lim : FULL_SCALE;
      clip = (v > m) ? m : v;
    end
  endfunction

  // last tick count of an interval; a zero timeout acts as one tick
  function [15:0] last_tick;
    input [15:0] t;
    begin
      if (t == 16'h0000) begin
        last_tick = 16'h0000;
      end else begin
        last_tick = t - 16'h0001;
      end
    end
  endfunction

  reg wdog_on;
  reg [15:0] tmo_cur;
  reg [15:0] tmo_pend;
  reg [15:0] tick_cnt16;
  reg [TICK_W-1:0] tick_div;
  reg [ACK_W-1:0] low_cnt;
  reg low_long;
  reg sb_prev;
  reg handoff_off;
  wire tick;
  wire tmo_take;
  wire en_take;
  wire analog_grab;
  wire expire;
  wire ack;
  wire take_analog;

  assign tick = (tick_div == TICK_CYC - 16'h0001);
  assign expire = digital_remote & wdog_on & tick & ~msg_valid &
    (tick_cnt16 >= last_tick(tmo_cur));
  assign tmo_take = tmo_wr & digital_remote;
  assign en_take = wdog_en_wr & digital_remote;
  // a digital request wins a same-cycle tie with the takeover pin
  assign analog_grab = take_analog & ~digital_remote & ~dig_take_req;
  assign ack = output_standby_pin & ~sb_prev & low_long;
  assign take_analog = ~takeover_pin & remote_allowed;

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      tick_div <= 16'h0000;
    end else if (tick) begin
      tick_div <= 16'h0000;
    end else begin
      tick_div <= tick_div + 16'h0001;
    end
  end

  // control location: one owner at a time
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      digital_remote <= 1'b0;
      analog_remote <= 1'b0;
      dig_take_err <= 1'b0;
      wdog_expired <= 1'b0;
    end else begin
      dig_take_err <= dig_take_req & analog_remote;
      wdog_expired <= expire;
      if (!remote_allowed || expire || dig_release_req) begin
        digital_remote <= 1'b0;
      end else if (dig_take_req && !analog_remote) begin
        digital_remote <= 1'b1;
      end
      if (!take_analog) begin
        analog_remote <= 1'b0;
      end else if (analog_grab) begin
        analog_remote <= 1'b1;
      end
    end
  end

  // link watchdog, separate from any network connection timeout
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      wdog_on <= 1'b0;
      tmo_cur <= `RCS_TMO_RST;
      tmo_pend <= `RCS_TMO_RST;
      tick_cnt16 <= 16'h0000;
    end else begin
      // writes from a link that is not in control are dropped
      if (en_take) begin
        wdog_on <= wdog_en_val;
      end
      if (tmo_take) begin
        tmo_pend <= tmo_val;
      end
      if (!digital_remote || !wdog_on) begin
        tick_cnt16 <= 16'h0000;
        tmo_cur <= tmo_take ? tmo_val : tmo_pend;
      end else if (msg_valid) begin
        tick_cnt16 <= 16'h0000;
      end else if (expire) begin
        tick_cnt16 <= 16'h0000;
        tmo_cur <= tmo_pend;
      end else if (tick) begin
        tick_cnt16 <= tick_cnt16 + 16'h0001;
      end
    end
  end

  // standby pin low-phase timing for acknowledge
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      low_cnt <= {ACK_W{1'b0}};
      low_long <= 1'b0;
      sb_prev <= 1'b1;
    end else begin
      sb_prev <= output_standby_pin;
      if (output_standby_pin) begin
        low_cnt <= {ACK_W{1'b0}};
        // kept through the rising edge so that ack can see it
        if (sb_prev) begin
          low_long <= 1'b0;
        end
      end else if (low_cnt != ACK_LOW_CYC) begin
        low_cnt <= low_cnt + {{(ACK_W-1){1'b0}}, 1'b1};
      end else begin
        low_long <= 1'b1;
      end
    end
  end

  // alarm latches; a new event wins over the acknowledge
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      alarm_latched <= 5'h00;
    end else begin
      alarm_latched <= alarm_raw |
        (alarm_latched & PROT_MASK & {5{~ack}});
    end
  end

  // an expiry that switched the output off holds it off until the
  // output request is dropped and given again
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      handoff_off <= 1'b0;
    end else if (expire && !handoff_keep_on) begin
      handoff_off <= 1'b1;
    end else if (!output_on_req) begin
      handoff_off <= 1'b0;
    end
  end

  // output enable
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      output_enable <= 1'b0;
    end else if ((|alarm_raw) || (|alarm_latched)) begin
      output_enable <= 1'b0;
    end else if (!output_standby_pin) begin
      output_enable <= 1'b0;
    end else if ((expire && !handoff_keep_on) || handoff_off) begin
      output_enable <= 1'b0;
    end else begin
      output_enable <= output_on_req;
    end
  end

  // set value source selection; thresholds never pass through here
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      set_v <= 16'h0000;
      set_i <= 16'h0000;
      set_p <= 16'h0000;
      set_r <= 16'h0000;
      r_from_analog <= 1'b0;
    end else if (analog_remote) begin
      set_v <= clip(voltage_setpoint_input, lim_v);
      set_i <= clip(current_setpoint_input, lim_i);
      set_p <= clip(power_setpoint_input, lim_p);
      r_from_analog <= resistance_mode_pin;
      set_r <= resistance_mode_pin ?
        clip(resistance_setpoint_input, lim_r) : clip(panel_r, lim_r);
    end else begin
      set_v <= clip(panel_v, lim_v);
      set_i <= clip(panel_i, lim_i);
      set_p <= clip(panel_p, lim_p);
      set_r <= clip(panel_r, lim_r);
      r_from_analog <= 1'b0;
    end
  end

  // analog outputs; held quiet until the start phase ends
  always @(posedge clk_sys) begin
    if (!reset_n || !start_done) begin
      voltage_actual_output <= 16'h0000;
      current_actual_output <= 16'h0000;
      ref_10v <= 1'b0;
      analog_alarm_thermal <= 1'b0;
      analog_alarm_protect <= 1'b0;
    end else begin
      voltage_actual_output <= clip(act_v, FULL_SCALE);
      current_actual_output <= clip(act_i, FULL_SCALE);
      ref_10v <= range_10v;
      analog_alarm_thermal <= |(alarm_latched & alarm_sel & 5'h03);
      analog_alarm_protect <= |(alarm_latched & alarm_sel & PROT_MASK);
    end
  end

endmodule // rcs_supervisor

// ---- include/rcs_defs.vh ----
// constants for the remote control supervisor
// assumes a 40 MHz system clock
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH
`define RCS_CLK_HZ 40000000
`define RCS_ACK_LOW_MS 50
`define RCS_ACK_LOW_CYC ((`RCS_CLK_HZ / 1000) * `RCS_ACK_LOW_MS)
`define RCS_TICK_US 1000
`define RCS_TICK_CYC ((`RCS_CLK_HZ / 1000000) * `RCS_TICK_US)
`define RCS_FULL_SCALE 16'h6666
`define RCS_SV_W 16
`define RCS_TMO_W 16
`define RCS_TMO_RST 16'h03E8
`define RCS_ALM_OH 0
`define RCS_ALM_PF 1
`define RCS_ALM_OV 2
`define RCS_ALM_OC 3
`define RCS_ALM_OP 4
`define RCS_ALM_W 5
`define RCS_ALM_SEL_RST 5'h1F
`endif

// ---- bench/rcs_props.sv ----
// assertion checker for the remote control supervisor
// sees only the top ports; bound at the foot of this file
`timescale 1ns/1ps
module rcs_props (
  input wire clk_sys, // clock
  input wire reset_n, // sync reset
  input wire dig_take_req, // take request
  input wire takeover_pin, // analog pin
  input wire handoff_keep_on, // keep on
  input wire [15:0] lim_v, // voltage limit
  input wire [4:0] alarm_raw, // raw alarms
  input wire [4:0] alarm_sel, // alarm routing
  input wire digital_remote, // digital control
  input wire analog_remote, // analog control
  input wire dig_take_err, // refusal pulse
  input wire wdog_expired, // expiry pulse
  input wire output_enable, // output on
  input wire [15:0] set_v, // voltage set
  input wire analog_alarm_protect // alarm out 2
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  a_take_refused: assert property (
    dig_take_req && analog_remote |=> dig_take_err && !digital_remote)
    else $error("take not refused");
  a_single_owner: assert property (
    !(digital_remote && analog_remote)) else $error("two owners");
  a_pin_needed: assert property (
    $rose(analog_remote) |-> !$past(takeover_pin)) else $error("no pin");
  a_idle_quiet: assert property (
    !$past(digital_remote) |-> !wdog_expired) else $error("idle expiry");
  a_expiry_leaves: assert property (
    wdog_expired |-> !digital_remote) else $error("still remote");
  a_expiry_off: assert property (
    wdog_expired && !$past(handoff_keep_on) |-> !output_enable)
    else $error("output left on");
  a_clip_v: assert property (
    analog_remote && $past(analog_remote) |-> set_v <= $past(lim_v))
    else $error("v not clipped");
  a_alarm_off: assert property (
    $past(|alarm_raw) |-> !output_enable) else $error("alarm output on");
  a_sel_mask: assert property (
    !$past(|alarm_sel[4:2]) |-> !analog_alarm_protect)
    else $error("unrouted alarm shown");
endmodule // rcs_props
bind rcs_supervisor rcs_props u_props (.clk_sys, .reset_n, .dig_take_req,
  .takeover_pin, .handoff_keep_on, .lim_v, .alarm_raw, .alarm_sel,
  .digital_remote, .analog_remote, .dig_take_err, .wdog_expired,
  .output_enable, .set_v, .analog_alarm_protect);

// ---- bench/rcs_ctrl_model.sv ----
// controller at the analog port: open collector pins with pull-ups
// assumes the bench sets its wishes as levels
`timescale 1ns/1ps
module rcs_ctrl_model (
  input wire want_analog, // ask for analog takeover
  input wire want_off, // ask for output standby
  input wire start_done, // device start phase over
  input wire alarm_in, // alarm output of the device
  output wire takeover_pin, // pulled up when released
  output wire output_standby_pin, // pulled up when released
  output wire alarm_seen // alarm as taken by the controller
);
  assign takeover_pin = want_analog ? 1'b0 : 1'b1;
  assign output_standby_pin = want_off ? 1'b0 : 1'b1;
  assign alarm_seen = start_done & alarm_in;
endmodule // rcs_ctrl_model

// ---- bench/test_rcs_supervisor.sv ----
// testbench for the remote control supervisor
// assumes the 1 ms tick and default widths of the design
`timescale 1ns/1ps
module test_rcs_supervisor;
  reg clk_sys, reset_n, start_done, tk, rl, mv, ew, ev, tw, keep, r10;
  reg rmode, on_req, want_analog, want_off, ra;
  reg [15:0] tv, v_in, i_in, p_in, r_in, lim_v, lim_i, lim_p, pan_r, a_v;
  reg [4:0] alarm_raw, alarm_sel;
  wire tpin, spin, seen, dr, ar, err, exp_p, oe, rfa, ref10, prot, therm;
  wire [15:0] set_v, set_i, set_p, set_r, vout, iout;
  wire [4:0] alarm_latched;
  integer mismatches, n_tests, cyc, k;
  rcs_ctrl_model model_u (.want_analog, .want_off, .start_done,
    .alarm_in(prot), .takeover_pin(tpin), .output_standby_pin(spin),
    .alarm_seen(seen));
  rcs_supervisor dut_u (.clk_sys, .reset_n, .start_done,
    .remote_allowed(ra), .dig_take_req(tk), .dig_release_req(rl),
    .msg_valid(mv), .wdog_en_wr(ew), .wdog_en_val(ev), .tmo_wr(tw),
    .tmo_val(tv), .handoff_keep_on(keep), .range_10v(r10),
    .takeover_pin(tpin), .resistance_mode_pin(rmode),
    .output_standby_pin(spin), .output_on_req(on_req),
    .voltage_setpoint_input(v_in), .current_setpoint_input(i_in),
    .power_setpoint_input(p_in), .resistance_setpoint_input(r_in),
    .panel_v(16'h0000), .panel_i(16'h0000), .panel_p(16'h0000),
    .panel_r(pan_r), .lim_v, .lim_i, .lim_p, .lim_r(16'h1000),
    .act_v(a_v), .act_i(16'h0100), .alarm_raw, .alarm_sel,
    .digital_remote(dr), .analog_remote(ar), .dig_take_err(err),
    .wdog_expired(exp_p), .output_enable(oe), .set_v, .set_i, .set_p,
    .set_r, .r_from_analog(rfa), .voltage_actual_output(vout),
    .current_actual_output(iout), .ref_10v(ref10), .alarm_latched,
    .analog_alarm_thermal(therm), .analog_alarm_protect(prot));
  task st(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #2;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  // one strobe at a time: 0 take, 1 timeout, 2 enable, 3 message, 4 release
  task pulse(input integer w, input [15:0] v);
    begin
      st(1);
      {tk, tw, ew, mv, rl} = {w == 0, w == 1, w == 2, w == 3, w == 4};
      tv = v;
      ev = v[0];
      st(1);
      {tk, tw, ew, mv, rl} = 5'h00;
    end
  endtask
  task wait_exp;
    begin
      k = 0;
      while (exp_p !== 1'b1 && k < 41000) begin
        st(1);
        k = k + 1;
      end
      chk(exp_p, 1);
    end
  endtask
  task complete_run;
    begin
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 95000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  initial begin
    {mismatches, n_tests, cyc} = 0;
    {reset_n, start_done, tk, rl, mv, ew, ev, tw, keep, rmode, on_req} = 0;
    {want_analog, want_off, tv, alarm_raw, alarm_sel} = 0;
    ra = 1;
    {r10, v_in, i_in, p_in, r_in} = {1'b1, 64'h5000_1234_7000_0222};
    {lim_v, lim_i, lim_p, pan_r, a_v} = 80'h3000_4000_FFFF_0111_FFFF;
    st(2);
    reset_n = 1;
    st(1);
    chk({vout, dr}, 0);
    start_done = 1;
    st(2);
    chk({ref10, vout}, 17'h16666);
    chk(iout, 16'h0100);
    pulse(0, 0);
    pulse(4, 0);
    chk(dr, 0);
    pulse(0, 0);
    want_analog = 1;
    st(2);
    chk({dr, ar}, 2);
    {want_analog, on_req} = 2'b01;
    pulse(2, 0);
    pulse(1, 1);
    pulse(2, 1);
    pulse(3, 0);
    chk(oe, 1);
    wait_exp;
    chk({dr, oe}, 0);
    st(2);
    chk(oe, 0);
    {keep, on_req} = 2'b10;
    st(1);
    on_req = 1;
    pulse(0, 0);
    pulse(1, 16'h0005);
    wait_exp;
    chk({dr, oe}, 1);
    want_off = 1;
    st(2);
    chk(oe, 0);
    want_off = 0;
    want_analog = 1;
    st(2);
    chk({ar, set_v}, 17'h13000);
    chk({set_i, set_p}, {16'h1234, 16'h6666});
    chk(set_r, 16'h0111);
    rmode = 1;
    st(2);
    chk({rfa, set_r}, 17'h10222);
    ra = 0;
    st(1);
    chk(ar, 0);
    ra = 1;
    st(1);
    chk(ar, 1);
    pulse(0, 0);
    chk({err, dr}, 2);
    alarm_raw = 5'h04;
    st(2);
    chk({alarm_latched, oe, prot}, 16'h0010);
    {alarm_raw, want_off} = 6'h01;
    st(10);
    want_off = 0;
    st(3);
    chk(alarm_latched, 5'h04);
    alarm_sel = 5'h1F;
    st(2);
    chk({prot, seen}, 3);
    alarm_raw = 5'h01;
    st(2);
    chk({therm, prot}, 3);
    alarm_raw = 5'h00;
    st(2);
    chk({therm, alarm_latched}, 6'h04);
    complete_run;
  end
endmodule // test_rcs_supervisor
